// >>> rtl/cppg_core.sv
`include "cppg_defines.svh"
`default_nettype none

module cppg_core (
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire cppg_pkg::cppg_wr_req_t  wr_req_i,
   input  wire logic [2:0]              rd_sel_i,
   input  wire cppg_pkg::cppg_clk_cfg_t clk_cfg_i,
   input  wire logic                    low_freq_clock_i,
   input  wire logic                    lower_timer_input_i,
   output logic [7:0]                   rd_data_o,
   output logic [15:0]                  count_o,
   output logic                         running_o,
   output logic                         cascade_match_irq_o,
   output logic                         pwm_output_pin_o,
   output logic                         ppg_output_pin_o
);

   logic [7:0]  ctrl_ff;
   logic [7:0]  cnt_lo_ff;
   logic [7:0]  cnt_hi_ff;
   logic [15:0] pulse_buf_ff;
   logic [15:0] pulse_act_ff;
   logic [15:0] period_ff;
   logic        out_lvl_ff;

   logic [7:0]  nxt_cnt_lo;
   logic [7:0]  nxt_cnt_hi;
   logic [15:0] nxt_pulse_buf;
   logic        nxt_out_lvl;
   logic        nxt_irq;
   logic [7:0]  nxt_rd_data;

   logic        lf_rise;
   logic        ext_rise;
   logic        tick;
   logic        run;
   logic        mode_pwm;
   logic        mode_ppg;
   logic        active;
   logic        ctrl_wr;
   logic        new_run;
   logic        pulse_wr;
   logic [15:0] cnt;
   logic [15:0] cnt_inc;
   logic        lo_wrap;
   logic        at_max;
   logic        pulse_hit;
   logic        period_hit;

   cppg_sync_edge #(
      .STABLE_CLKS (1)
   ) u_lf_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pin_i   (low_freq_clock_i),
      .rise_o  (lf_rise)
   );

   cppg_sync_edge #(
      .STABLE_CLKS (`CPPG_EXT_LEVEL_CLKS)
   ) u_ext_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pin_i   (lower_timer_input_i),
      .rise_o  (ext_rise)
   );

   // Tick lags its source event by one clock, the same for every source
   cppg_prescale u_prescale (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .cfg_i      (clk_cfg_i),
      .lf_rise_i  (lf_rise),
      .ext_rise_i (ext_rise),
      .tick_o     (tick)
   );

   // Control decode
   // Writes are one-cycle strobes from logic on this clock, so they need no synchroniser
   assign run      = ctrl_ff[`CPPG_CTRL_RUN_BIT];
   assign mode_pwm = ctrl_ff[`CPPG_CTRL_MODE_MSB:`CPPG_CTRL_MODE_LSB] == `CPPG_MODE_PWM16;
   assign mode_ppg = ctrl_ff[`CPPG_CTRL_MODE_MSB:`CPPG_CTRL_MODE_LSB] == `CPPG_MODE_PPG16;
   // Other mode codes leave the counter idle; those modes live elsewhere
   assign active   = run && (mode_pwm || mode_ppg);

   assign ctrl_wr  = wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_UPPER_CTRL);
   assign new_run  = wr_req_i.data[`CPPG_CTRL_RUN_BIT];
   assign pulse_wr = wr_req_i.wr && ((wr_req_i.sel == `CPPG_SEL_PULSE_LOW)
                                  || (wr_req_i.sel == `CPPG_SEL_PULSE_HIGH));

   // Chained counter: high byte carries from the low byte's wrap
   assign cnt     = {cnt_hi_ff, cnt_lo_ff};
   assign lo_wrap = cnt_lo_ff == 8'hFF;
   assign cnt_inc = {cnt_hi_ff + {7'h00, lo_wrap}, cnt_lo_ff + 8'h01};
   assign at_max  = cnt == `CPPG_CNT_MAX;

   // Matches are judged on the value the counter is about to take
   assign pulse_hit  = cnt_inc == pulse_act_ff;
   assign period_hit = cnt_inc == period_ff;

   // Count, toggle and interrupt generation
   always_comb
   begin
      nxt_cnt_lo  = cnt_lo_ff;
      nxt_cnt_hi  = cnt_hi_ff;
      nxt_out_lvl = out_lvl_ff;
      nxt_irq     = 1'b0;
      if (ctrl_wr && !run)
      begin
         // Stopped: initial level loads the flip-flop, start clears the count
         nxt_out_lvl = wr_req_i.data[`CPPG_CTRL_INIT_BIT];
         nxt_cnt_lo  = 8'h00;
         nxt_cnt_hi  = 8'h00;
      end
      else if (ctrl_wr && !new_run)
      begin
         // Stopping write: the pin keeps its level, the new bit 7 is not applied
         nxt_out_lvl = out_lvl_ff;
         // Stopped is the only safe state before a power-down: only a control write moves the pin
         nxt_cnt_lo  = cnt_lo_ff;
         nxt_cnt_hi  = cnt_hi_ff;
      end
      else if (active && tick)
      begin
         nxt_cnt_lo = cnt_inc[7:0];
         nxt_cnt_hi = cnt_inc[15:8];
         if (mode_pwm)
         begin
            if (at_max)
            begin
               // Overflow wins the cycle; pulse match on zero is folded in
               nxt_cnt_lo  = 8'h00;
               nxt_cnt_hi  = 8'h00;
               nxt_irq     = 1'b1;
               nxt_out_lvl = out_lvl_ff ^ 1'b1 ^ pulse_hit;
            end
            else if (pulse_hit)
               nxt_out_lvl = !out_lvl_ff;
         end
         else
         begin
            if (period_hit)
            begin
               nxt_cnt_lo  = 8'h00;
               nxt_cnt_hi  = 8'h00;
               nxt_irq     = 1'b1;
               // Equal compares cancel, giving a steady level
               nxt_out_lvl = out_lvl_ff ^ 1'b1 ^ pulse_hit;
            end
            else if (pulse_hit)
               nxt_out_lvl = !out_lvl_ff;
         end
      end
   end

   // Both bytes update together, so the carry never lags the low byte by a clock
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_lo_ff <= 8'h00;
         cnt_hi_ff <= 8'h00;
      end
      else
      begin
         cnt_lo_ff <= nxt_cnt_lo;
         cnt_hi_ff <= nxt_cnt_hi;
      end
   end

   // Bit 7 is stored on every write but reaches the flip-flop only while stopped
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ctrl_ff <= `CPPG_CTRL_RESET;
      else if (ctrl_wr)
         ctrl_ff <= wr_req_i.data;
   end

   // Output flip-flop plus pins taken from the same next value
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         out_lvl_ff       <= 1'b0;
         // Pins idle high: the inverse of the cleared flip-flop
         pwm_output_pin_o <= 1'b1;
         ppg_output_pin_o <= 1'b1;
      end
      else
      begin
         out_lvl_ff       <= nxt_out_lvl;
         pwm_output_pin_o <= !nxt_out_lvl;
         ppg_output_pin_o <= !nxt_out_lvl;
      end
   end

   // One-cycle event; in PWM mode also the moment the buffered pulse value is shifted in
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         cascade_match_irq_o <= 1'b0;
      else
         cascade_match_irq_o <= nxt_irq;
   end

   // Pulse compare: writes land in the buffer byte by byte
   always_comb
   begin
      nxt_pulse_buf = pulse_buf_ff;
      if (wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_PULSE_LOW))
         nxt_pulse_buf[7:0] = wr_req_i.data;
      if (wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_PULSE_HIGH))
         nxt_pulse_buf[15:8] = wr_req_i.data;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pulse_buf_ff <= `CPPG_CMP_RESET;
      else
         pulse_buf_ff <= nxt_pulse_buf;
   end

   // A write in the interrupt cycle is shifted in with it; software avoids that
   // Stopped writes and all PPG writes bypass the buffer
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pulse_act_ff <= `CPPG_CMP_RESET;
      else if (nxt_irq && mode_pwm)
         pulse_act_ff <= nxt_pulse_buf;
      else if (pulse_wr && (!run || mode_ppg))
         pulse_act_ff <= nxt_pulse_buf;
   end

   // Period compare has no buffer and acts at once
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         period_ff <= `CPPG_CMP_RESET;
      else if (wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_PERIOD_LOW))
         period_ff[7:0] <= wr_req_i.data;
      else if (wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_PERIOD_HIGH))
         period_ff[15:8] <= wr_req_i.data;
   end

   // Reads of pulse compare show the buffer, not the active value
   // In PPG mode every write reaches both, so they differ only while a value buffered in PWM mode is pending
   always_comb
   begin
      case (rd_sel_i)
         `CPPG_SEL_UPPER_CTRL:  nxt_rd_data = ctrl_ff;
         `CPPG_SEL_PULSE_LOW:   nxt_rd_data = pulse_buf_ff[7:0];
         `CPPG_SEL_PULSE_HIGH:  nxt_rd_data = pulse_buf_ff[15:8];
         `CPPG_SEL_PERIOD_LOW:  nxt_rd_data = period_ff[7:0];
         `CPPG_SEL_PERIOD_HIGH: nxt_rd_data = period_ff[15:8];
         default:               nxt_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_o <= 8'h00;
         count_o   <= 16'h0000;
         running_o <= 1'b0;
      end
      else
      begin
         // count_o takes the counter's next value, so it always equals the counter
         rd_data_o <= nxt_rd_data;
         count_o   <= {nxt_cnt_hi, nxt_cnt_lo};
         running_o <= active;
      end
   end

endmodule : cppg_core

`default_nettype wire

// >>> rtl/cppg_defines.svh
`ifndef CPPG_DEFINES_SVH
`define CPPG_DEFINES_SVH

// Register select codes on the write and read ports
`define CPPG_SEL_UPPER_CTRL   3'h0
`define CPPG_SEL_PULSE_LOW    3'h1
`define CPPG_SEL_PULSE_HIGH   3'h2
`define CPPG_SEL_PERIOD_LOW   3'h3
`define CPPG_SEL_PERIOD_HIGH  3'h4

// Upper control register fields
`define CPPG_CTRL_INIT_BIT    7
`define CPPG_CTRL_RUN_BIT     3
`define CPPG_CTRL_MODE_MSB    2
`define CPPG_CTRL_MODE_LSB    0
`define CPPG_MODE_PWM16       3'h6
`define CPPG_MODE_PPG16       3'h7

// Reset values and counter maximum
`define CPPG_CTRL_RESET       8'h00
`define CPPG_CMP_RESET        16'h0000
`define CPPG_CNT_MAX          16'hFFFF

// Prescaler tap widths: divide by 2^n ends when n low bits are all ones
`define CPPG_DIV_W            11
`define CPPG_TAP_2_11         11
`define CPPG_TAP_2_7          7
`define CPPG_TAP_2_5          5
`define CPPG_TAP_2_3          3
`define CPPG_LF_DIV_W         3

// External input: each level lasts two machine cycles of four clocks
`define CPPG_EXT_LEVEL_MCYC   2
`define CPPG_MCYC_CLKS        4
`define CPPG_EXT_LEVEL_CLKS   (`CPPG_EXT_LEVEL_MCYC * `CPPG_MCYC_CLKS)

`endif

// >>> rtl/cppg_pkg.sv
`default_nettype none

package cppg_pkg;

   typedef enum logic [2:0] {
      CPPG_SRC_DIV2_11 = 3'h0,
      CPPG_SRC_DIV2_7  = 3'h1,
      CPPG_SRC_DIV2_5  = 3'h2,
      CPPG_SRC_DIV2_3  = 3'h3,
      CPPG_SRC_LF      = 3'h4,
      CPPG_SRC_DIV2    = 3'h5,
      CPPG_SRC_HF      = 3'h6,
      CPPG_SRC_EXT     = 3'h7
   } cppg_src_t;

   typedef struct packed {
      logic       wr;
      logic [2:0] sel;
      logic [7:0] data;
   } cppg_wr_req_t;

   typedef struct packed {
      cppg_src_t src;
      logic      divider_source_select;
      logic      slow_mode;
   } cppg_clk_cfg_t;

endpackage : cppg_pkg

`default_nettype wire

// >>> rtl/cppg_sync_edge.sv
`include "cppg_defines.svh"
`default_nettype none

module cppg_sync_edge #(
   parameter int STABLE_CLKS = 1
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,
   output logic      rise_o
);

   logic       meta_ff;
   logic       sync_ff;
   logic       level_ff;
   logic [7:0] stable_ff;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
      end
   end

   // A level is only accepted after it has stood long enough
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         level_ff  <= 1'b0;
         stable_ff <= 8'h00;
         rise_o    <= 1'b0;
      end
      else
      begin
         rise_o <= 1'b0;
         if (sync_ff == level_ff)
            stable_ff <= 8'h00;
         else if (stable_ff >= 8'(STABLE_CLKS - 1))
         begin
            level_ff  <= sync_ff;
            stable_ff <= 8'h00;
            rise_o    <= sync_ff;
         end
         else
            stable_ff <= stable_ff + 8'h01;
      end
   end

endmodule : cppg_sync_edge

`default_nettype wire

// >>> rtl/cppg_prescale.sv
`include "cppg_defines.svh"
`default_nettype none

module cppg_prescale (
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire cppg_pkg::cppg_clk_cfg_t cfg_i,
   input  wire logic                   lf_rise_i,
   input  wire logic                   ext_rise_i,
   output logic                        tick_o
);

   logic [`CPPG_DIV_W-1:0]    div_ff;
   logic [`CPPG_LF_DIV_W-1:0] lf_div_ff;
   logic                      use_lf8;
   logic                      nxt_tick;

   // Free-running dividers, so the selected tap never restarts on a mode change
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         div_ff    <= '0;
         lf_div_ff <= '0;
      end
      else
      begin
         div_ff <= div_ff + `CPPG_DIV_W'(1);
         if (lf_rise_i)
            lf_div_ff <= lf_div_ff + `CPPG_LF_DIV_W'(1);
      end
   end

   assign use_lf8 = cfg_i.divider_source_select | cfg_i.slow_mode;

   // Source choice; in slow mode the fast-clock taps do not run
   always_comb
   begin
      nxt_tick = 1'b0;
      case (cfg_i.src)
         cppg_pkg::CPPG_SRC_DIV2_11:
            nxt_tick = use_lf8 ? (lf_rise_i && (&lf_div_ff))
                               : (&div_ff[`CPPG_TAP_2_11-1:0]);
         cppg_pkg::CPPG_SRC_DIV2_7:
            nxt_tick = !cfg_i.slow_mode && (&div_ff[`CPPG_TAP_2_7-1:0]);
         cppg_pkg::CPPG_SRC_DIV2_5:
            nxt_tick = !cfg_i.slow_mode && (&div_ff[`CPPG_TAP_2_5-1:0]);
         cppg_pkg::CPPG_SRC_DIV2_3:
            nxt_tick = !cfg_i.slow_mode && (&div_ff[`CPPG_TAP_2_3-1:0]);
         cppg_pkg::CPPG_SRC_LF:
            nxt_tick = lf_rise_i;
         cppg_pkg::CPPG_SRC_DIV2:
            nxt_tick = !cfg_i.slow_mode && div_ff[0];
         cppg_pkg::CPPG_SRC_HF:
            nxt_tick = !cfg_i.slow_mode;
         cppg_pkg::CPPG_SRC_EXT:
            nxt_tick = ext_rise_i;
         default:
            nxt_tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         tick_o <= 1'b0;
      else
         tick_o <= nxt_tick;
   end

endmodule : cppg_prescale

`default_nettype wire

// >>> verification/cppg_core_checker.sv
`include "cppg_defines.svh"
`default_nettype none

module cppg_core_checker (
   input wire logic                    clk_i,
   input wire logic                    rst_n_i,
   input wire cppg_pkg::cppg_wr_req_t  wr_req_i,
   input wire cppg_pkg::cppg_clk_cfg_t clk_cfg_i,
   input wire logic [15:0]             count_o,
   input wire logic                    running_o,
   input wire logic                    cascade_match_irq_o,
   input wire logic                    pwm_output_pin_o,
   input wire logic                    ppg_output_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic ctrl_wr;

   assign ctrl_wr = wr_req_i.wr && (wr_req_i.sel == `CPPG_SEL_UPPER_CTRL);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   pins_agree_a: assert property (pwm_output_pin_o == ppg_output_pin_o)
      else $error("pulse pins disagree");
   irq_clears_a: assert property (cascade_match_irq_o |-> count_o == 16'h0000)
      else $error("event without counter clear");
   wrap_irq_a: assert property (running_o && $past(running_o) &&
      $past(count_o) == 16'hFFFF && count_o == 16'h0000 |-> cascade_match_irq_o)
      else $error("overflow without event");
   irq_toggle_a: assert property ($rose(cascade_match_irq_o) |->
      pwm_output_pin_o != $past(pwm_output_pin_o))
      else $error("event without pin toggle");
   count_step_a: assert property (running_o && $past(running_o) &&
      !$past(wr_req_i.wr) && clk_cfg_i.src == cppg_pkg::CPPG_SRC_HF &&
      $past(clk_cfg_i.src) == cppg_pkg::CPPG_SRC_HF |->
      count_o == $past(count_o) + 16'h0001 || cascade_match_irq_o)
      else $error("counter missed a step");
   stop_hold_a: assert property (!running_o && !$past(running_o) &&
      !$past(wr_req_i.wr) |-> $stable(pwm_output_pin_o) && $stable(count_o))
      else $error("stopped timer moved");
   init_level_a: assert property (ctrl_wr && !running_o && !wr_req_i.data[3] |->
      ##2 pwm_output_pin_o == !$past(wr_req_i.data[7], 2))
      else $error("initial level not applied");
   run_ctrl_a: assert property (ctrl_wr && wr_req_i.data[2:1] == 2'h3 |->
      ##2 running_o == $past(wr_req_i.data[3], 2))
      else $error("run control not followed");
endmodule : cppg_core_checker

bind cppg_core cppg_core_checker u_checker (.clk_i, .rst_n_i, .wr_req_i, .clk_cfg_i, .count_o,
   .running_o, .cascade_match_irq_o, .pwm_output_pin_o, .ppg_output_pin_o);

`default_nettype wire

// >>> verification/cppg_load.sv
`default_nettype none

// Load on the pulse pin, taken as seen through a port latch held at 1
module cppg_load (
   input  wire logic    clk_i,
   input  wire logic    rst_n_i,
   input  wire logic    pin_i,
   output logic [15:0]  width_o,
   output logic         valid_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic        pin_ff;
   logic [15:0] cnt_ff;

   // Reports the length of each low level, in clocks, when the pin rises
   always_ff @(posedge clk_i)
   begin
      valid_o <= 1'b0;
      if (!rst_n_i)
      begin
         pin_ff  <= 1'b1;
         cnt_ff  <= 16'h0000;
         width_o <= 16'h0000;
      end
      else
      begin
         pin_ff <= pin_i;
         if (!pin_i)
            cnt_ff <= cnt_ff + 16'h0001;
         else if (!pin_ff)
         begin
            width_o <= cnt_ff;
            valid_o <= 1'b1;
            cnt_ff  <= 16'h0000;
         end
      end
   end
endmodule : cppg_load

`default_nettype wire

// >>> verification/tb_cascaded_16bit_pwm_ppg.sv
`include "cppg_defines.svh"
`default_nettype none

module tb_cascaded_16bit_pwm_ppg;
   timeunit 1ns;
   timeprecision 1ns;

   logic                    clk_i, rst_n_i, low_freq_clock_i, lower_timer_input_i;
   cppg_pkg::cppg_wr_req_t  wr_req_i;
   cppg_pkg::cppg_clk_cfg_t clk_cfg_i;
   logic [2:0]              rd_sel_i;
   logic [7:0]              rd_data_o;
   logic [15:0]             count_o, width, p, q;
   logic                    running_o, cascade_match_irq_o, valid;
   logic                    pwm_output_pin_o, ppg_output_pin_o;
   int                      n_errors = 0, checks_done = 0, cyc = 0, seed = 12;
   logic [15:0]             exp_q[$];
   logic [2:0]              sv [10] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h7,
                                        3'h0, 3'h0};
   logic [15:0]             dv [10] = '{16'h1, 16'h2, 16'h8, 16'h20, 16'h80, 16'h800,
                                        16'h14, 16'h14, 16'hA0, 16'hA0};

   cppg_core dut (.clk_i, .rst_n_i, .wr_req_i, .rd_sel_i, .clk_cfg_i, .low_freq_clock_i,
      .lower_timer_input_i, .rd_data_o, .count_o, .running_o, .cascade_match_irq_o,
      .pwm_output_pin_o, .ppg_output_pin_o);
   cppg_load u_load (.clk_i, .rst_n_i, .pin_i(pwm_output_pin_o), .width_o(width),
      .valid_o(valid));

   always #25 clk_i = ~clk_i;
   // Slow inputs hold each level 10 clocks, above the 8-clock minimum
   always #500 low_freq_clock_i = ~low_freq_clock_i;
   always #500 lower_timer_input_i = ~lower_timer_input_i;

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(negedge clk_i);
      wr_req_i = '{1'b1, s, d};
      @(negedge clk_i);
      wr_req_i.wr = 1'b0;
   endtask : wr

   task automatic wr16(input logic [2:0] s, input logic [15:0] v);
      wr(s, v[7:0]);
      wr(s + 3'h1, v[15:8]);
   endtask : wr16

   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      @(negedge clk_i);
      rd_sel_i = s;
      @(negedge clk_i);
      chk("rd_data", {8'h00, e}, {8'h00, rd_data_o});
   endtask : rd

   // Compares change only while stopped, since they act at once in this mode
   task automatic ppg(input logic [15:0] pr, input logic [15:0] pw, input logic [15:0] w);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h57);
      wr16(`CPPG_SEL_PERIOD_LOW, pr);
      wr16(`CPPG_SEL_PULSE_LOW, pw);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h5F);
      while (pwm_output_pin_o !== 1'b0) @(negedge clk_i);
      exp_q.push_back(w);
      while (exp_q.size() != 0) @(negedge clk_i);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h57);
   endtask : ppg

   always @(posedge clk_i)
      if (valid === 1'b1 && exp_q.size() != 0)
         chk("low_width", exp_q.pop_front(), width);

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 98000)
      begin
         n_errors++;
         complete_run();
      end
   end

   initial
   begin
      clk_i = 1'b0;
      rst_n_i = 1'b0;
      low_freq_clock_i = 1'b0;
      lower_timer_input_i = 1'b0;
      wr_req_i = '0;
      rd_sel_i = 3'h0;
      clk_cfg_i = '{cppg_pkg::CPPG_SRC_HF, 1'b0, 1'b0};
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk("pin_reset", 16'h0001, {15'h0, pwm_output_pin_o});
      wr(3'h5, 8'hAA);
      rd(3'h5, 8'h00);
      // Every source: the low level spans two source ticks
      for (int i = 0; i < 10; i++)
      begin
         clk_cfg_i = '{cppg_pkg::cppg_src_t'(sv[i]), i == 8, i == 9};
         ppg(16'h0004, 16'h0002, 16'h0002 * dv[i]);
      end
      clk_cfg_i = '{cppg_pkg::CPPG_SRC_HF, 1'b0, 1'b0};
      for (int i = 0; i < 6; i++)
      begin
         p = 16'h0003 + 16'($random(seed) & 15);
         q = 16'h0001 + 16'($unsigned($random(seed)) % (p - 16'h0001));
         ppg(p, q, p - q);
      end
      // Stopping mid-pulse keeps the pin low until the level bit is written again
      wr16(`CPPG_SEL_PERIOD_LOW, 16'h0100);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h5F);
      while (pwm_output_pin_o !== 1'b0) @(negedge clk_i);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h57);
      repeat (4) @(negedge clk_i);
      chk("held_pin", 16'h0000, {15'h0, pwm_output_pin_o});
      wr(`CPPG_SEL_UPPER_CTRL, 8'h57);
      chk("cleared_level", 16'h0001, {15'h0, pwm_output_pin_o});
      wr(`CPPG_SEL_UPPER_CTRL, 8'hD7);
      chk("set_level", 16'h0000, {15'h0, ppg_output_pin_o});
      // Running write must wait for overflow, or the pin would fall at 0010
      wr(`CPPG_SEL_UPPER_CTRL, 8'h56);
      wr16(`CPPG_SEL_PULSE_LOW, 16'hFFF0);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h5E);
      wr16(`CPPG_SEL_PULSE_LOW, 16'h0010);
      rd(`CPPG_SEL_PULSE_LOW, 8'h10);
      rd(`CPPG_SEL_PULSE_HIGH, 8'h00);
      while (count_o < 16'hFFE0) @(negedge clk_i);
      exp_q.push_back(16'h0010);
      while (exp_q.size() != 0) @(negedge clk_i);
      while (pwm_output_pin_o !== 1'b0) @(negedge clk_i);
      chk("pwm_match", 16'h0010, count_o);
      wr(`CPPG_SEL_UPPER_CTRL, 8'h56);
      complete_run();
   end
endmodule : tb_cascaded_16bit_pwm_ppg

`default_nettype wire
